// >>> dv/dcc_far_model.sv
`timescale 1ns/1ps
`include "dcc_defines.svh"

module dcc_far_model (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // bench controls
  input  wire logic                      src_on,
  input  wire logic                      hw_src_on,
  input  wire logic [`DCC_HW_IF_N-1:0]   hw_dst_on,
  input  wire logic                      sink_on,
  // source peripheral
  output logic                           src_hw_req,
  output dcc_pkg::dcc_word_t             src_word,
  input  wire logic                      src_ready,
  // destination peripheral
  output logic [`DCC_HW_IF_N-1:0]        dst_hw_req,
  input  wire dcc_pkg::dcc_word_t        dst_word,
  output logic                           dst_ready,
  // results
  output logic [31:0]                    rx_cnt,
  output logic                           rx_bad
);
  logic [31:0] tx_val;
  logic [31:0] rx_val;

  assign src_hw_req = hw_src_on;
  assign dst_hw_req = hw_dst_on;
  assign dst_ready  = sink_on;
  // idle data is inverted so a stale word never looks fresh
  assign src_word.valid = src_on;
  assign src_word.data  = src_on ? tx_val : ~tx_val;

  // words must arrive in the order sent, none lost or doubled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_val <= 32'ha5a50000;
      rx_val <= 32'ha5a50000;
      rx_cnt <= 32'h0;
      rx_bad <= 1'b0;
    end else begin
      if (src_word.valid && src_ready) begin
        tx_val <= tx_val + 32'h1;
      end
      if (dst_word.valid && dst_ready) begin
        rx_val <= rx_val + 32'h1;
        rx_cnt <= rx_cnt + 32'h1;
        if (dst_word.data !== rx_val) begin
          rx_bad <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> dv/test_dma_channel_config_low.sv
`timescale 1ns/1ps
`include "dcc_defines.svh"

module test_dma_channel_config_low;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  dcc_pkg::dcc_apb_req_t  apb_req;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   src_hw_req;
  dcc_pkg::dcc_word_t     src_word;
  logic                   src_ready;
  logic [1:0]             dst_hw_req;
  dcc_pkg::dcc_word_t     dst_word;
  logic                   dst_ready;
  logic [2:0]             ch_rank;
  logic [2:0]             peer_rank;
  logic                   peer_req;
  logic                   ch_wins;
  logic                   src_on;
  logic                   hw_src;
  logic [1:0]             hw_dst;
  logic                   sink_on;
  logic [31:0]            rx_cnt;
  logic                   rx_bad;
  logic [31:0]            q;
  logic [31:0]            base;
  int                     error_cnt;
  int                     checked;
  int                     cycles;

  dcc_channel dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_hw_req(src_hw_req), .src_word(src_word),
    .src_ready(src_ready), .dst_hw_req(dst_hw_req), .dst_word(dst_word),
    .dst_ready(dst_ready), .ch_rank(ch_rank), .peer_rank(peer_rank),
    .peer_req(peer_req), .ch_wins(ch_wins)
  );

  dcc_far_model far (
    .pclk(pclk), .presetn(presetn), .src_on(src_on),
    .hw_src_on(hw_src), .hw_dst_on(hw_dst), .sink_on(sink_on),
    .src_hw_req(src_hw_req), .src_word(src_word),
    .src_ready(src_ready), .dst_hw_req(dst_hw_req),
    .dst_word(dst_word), .dst_ready(dst_ready),
    .rx_cnt(rx_cnt), .rx_bad(rx_bad)
  );

  always #5 pclk = ~pclk;

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (checked > 0 && error_cnt == 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    apb_req <= '{paddr: a, pwrite: w, pwdata: d, pstrb: 4'hf};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        er;
    apb(a, 1'b1, d, rq, er);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rq);
    logic er;
    apb(a, 1'b0, 32'h0, rq, er);
  endtask

  task automatic t_reset;
    logic er;
    rd(`DCC_OFF_CFG_LOW, q);
    chk(q, 32'h00000e00);
    wr(12'h0fc, 32'hffffffff);
    apb(12'h0fc, 1'b0, 32'h0, q, er);
    chk(q, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_reserved;
    wr(`DCC_OFF_CFG_LOW, 32'hffffff3f);
    rd(`DCC_OFF_CFG_LOW, q);
    chk(q, 32'h00000f20);
    chk({29'h0, ch_rank}, 32'h1);
    wr(`DCC_OFF_CFG_LOW, 32'h00000c20);
    $display("test reserved done");
  endtask

  // fill until refused, then hold and drain as a clean stop would
  task automatic t_fifo_hold;
    int n;
    @(posedge pclk);
    sink_on <= 1'b0;
    src_on  <= 1'b1;
    wr(`DCC_OFF_CTRL, 32'h7);
    cyc(10);
    chk({31'h0, src_ready}, 32'h0);
    chk({31'h0, dst_word.valid}, 32'h1);
    rd(`DCC_OFF_STATUS, q);
    chk({29'h0, q[4:2]}, 32'h4);
    rd(`DCC_OFF_CFG_LOW, q);
    chk({31'h0, q[9]}, 32'h0);
    wr(`DCC_OFF_CFG_LOW, 32'h00000d20);
    sink_on <= 1'b1;
    for (n = 0; n < 10; n++) begin
      rd(`DCC_OFF_CFG_LOW, q);
      chk({31'h0, src_ready}, 32'h0);
      if (q[9] === 1'b1) break;
    end
    chk({31'h0, q[9]}, 32'h1);
    chk(rx_cnt, 32'h4);
    wr(`DCC_OFF_CFG_LOW, 32'h00000c20);
    cyc(4);
    chk({31'h0, src_ready}, 32'h1);
    @(posedge pclk);
    src_on <= 1'b0;
    cyc(8);
    wr(`DCC_OFF_CTRL, 32'h0);
    $display("test fifo hold done");
  endtask

  task automatic t_src_hs;
    @(posedge pclk);
    hw_src <= 1'b1;
    src_on <= 1'b1;
    wr(`DCC_OFF_CTRL, 32'h5);
    cyc(6);
    chk({31'h0, src_ready}, 32'h0);
    base = rx_cnt;
    wr(`DCC_OFF_SWREQ, 32'h1);
    cyc(10);
    chk(rx_cnt, base + 32'h1);
    wr(`DCC_OFF_CFG_LOW, 32'h00000420);
    hw_src <= 1'b0;
    wr(`DCC_OFF_SWREQ, 32'h1);
    cyc(6);
    chk({31'h0, src_ready}, 32'h0);
    @(posedge pclk);
    hw_src <= 1'b1;
    cyc(6);
    chk({31'h0, src_ready}, 32'h1);
    @(posedge pclk);
    src_on <= 1'b0;
    hw_src <= 1'b0;
    cyc(8);
    wr(`DCC_OFF_CTRL, 32'h0);
    $display("test source handshake done");
  endtask

  task automatic t_dst_hs;
    logic [2:0] pr [3] = '{3'h0, 3'h1, 3'h2};
    logic       win [3] = '{1'b1, 1'b1, 1'b0};
    base = rx_cnt;
    wr(`DCC_OFF_CFG_LOW, 32'h00000820);
    hw_dst <= 2'b01;
    src_on <= 1'b1;
    wr(`DCC_OFF_CTRL, 32'h0b);
    cyc(10);
    @(posedge pclk);
    src_on <= 1'b0;
    chk({31'h0, dst_word.valid}, 32'h0);
    wr(`DCC_OFF_SWREQ, 32'h2);
    cyc(4);
    chk({31'h0, dst_word.valid}, 32'h0);
    @(posedge pclk);
    hw_dst <= 2'b10;
    cyc(10);
    chk(rx_cnt, base + 32'h4);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      peer_req  <= 1'b1;
      peer_rank <= pr[i];
      cyc(1);
      chk({31'h0, ch_wins}, {31'h0, win[i]});
    end
    @(posedge pclk);
    peer_req <= 1'b0;
    hw_dst   <= 2'b00;
    wr(`DCC_OFF_CTRL, 32'h0);
    $display("test destination handshake done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    apb_req = '0;
    peer_rank = 3'h0;
    peer_req = 1'b0;
    src_on = 1'b0;
    hw_src = 1'b0;
    hw_dst = 2'b00;
    sink_on = 1'b1;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_reserved;
    t_fifo_hold;
    t_src_hs;
    t_dst_hs;
    chk({31'h0, rx_bad}, 32'h0);
    print_verdict;
  end
endmodule

// >>> inc/dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// register byte offsets inside the channel window
`define DCC_OFF_CTRL      12'h000
`define DCC_OFF_SWREQ     12'h004
`define DCC_OFF_STATUS    12'h008
`define DCC_OFF_CFG_LOW   12'h098

// channel_config_low fields
`define DCC_CFG_SRC_HS    11
`define DCC_CFG_DST_HS    10
`define DCC_CFG_EMPTY     9
`define DCC_CFG_HOLD      8
`define DCC_CFG_RANK_MSB  7
`define DCC_CFG_RANK_LSB  5
`define DCC_RST_SRC_HS    1'b1
`define DCC_RST_DST_HS    1'b1
`define DCC_RST_HOLD      1'b0
`define DCC_RST_RANK      3'h0
`define DCC_RANK_W        3

// control register fields
`define DCC_CTRL_EN       0
`define DCC_CTRL_SRC_MEM  1
`define DCC_CTRL_DST_MEM  2
`define DCC_CTRL_DSEL_LSB 3
`define DCC_CTRL_DSEL_MSB 6
`define DCC_DSEL_W        4
`define DCC_HW_IF_N       2

// software request register fields
`define DCC_SWREQ_SRC     0
`define DCC_SWREQ_DST     1

// status register fields
`define DCC_ST_STATE_LSB  0
`define DCC_ST_STATE_MSB  1
`define DCC_ST_CNT_LSB    2
`define DCC_ST_CNT_MSB    4
`define DCC_ST_SRC_PEND   5
`define DCC_ST_DST_PEND   6

// data path
`define DCC_DATA_W        32
`define DCC_FIFO_D        4
`define DCC_CNT_W         3
`define DCC_ADDR_W        12

`endif

// >>> inc/dcc_pkg.sv
`include "dcc_defines.svh"

package dcc_pkg;

  // channel state, gray along idle -> run -> hold
  typedef enum logic [1:0] {
    DCC_IDLE = 2'h0,
    DCC_RUN  = 2'h1,
    DCC_HOLD = 2'h3
  } dcc_state_t;

  typedef struct packed {
    logic [`DCC_ADDR_W-1:0] paddr;
    logic                   pwrite;
    logic [`DCC_DATA_W-1:0] pwdata;
    logic [3:0]             pstrb;
  } dcc_apb_req_t;

  typedef struct packed {
    logic                   valid;
    logic [`DCC_DATA_W-1:0] data;
  } dcc_word_t;

  typedef struct packed {
    logic                   src_hs;
    logic                   dst_hs;
    logic                   hold;
    logic [`DCC_RANK_W-1:0] rank;
  } dcc_cfg_t;

  typedef struct packed {
    logic                   en;
    logic                   src_mem;
    logic                   dst_mem;
    logic [`DCC_DSEL_W-1:0] dsel;
  } dcc_ctrl_t;

endpackage

// >>> rtl/dcc_channel.sv
// Notes on behaviour
// R1 - source_handshake_choice resets to 1; 0 takes only hardware source requests, 1 only software ones.
// R2 - destination_handshake_choice resets to 1; 0 takes only hardware destination requests, 1 only software ones.
// R3 - with a memory source the source choice is not looked at.
// R4 - with a memory destination the destination choice is not looked at.
// R5 - the empty bit reads 1 while the channel FIFO holds nothing, 0 otherwise, and resets to 1.
// R6 - while channel_hold is set no word is taken from the source; clearing it resumes, reset value 0.
// R7 - hold takes effect at once and may leave a source transaction unfinished; the code stops taking words one cycle after the hold bit is set.
// R8 - software stops cleanly by setting hold, polling empty until 1, then disabling.
// R9 - channel_rank is three bits resetting to 0; 7 wins arbitration, 0 loses.
// R10 - software writes channel_rank only with 0 or 1.
// R11 - with hardware destination handshake the interface named by destination_hw_interface_sel (0-1) is used, else ignored.
// R12 - reserved bits of channel_config_low read zero and writes to them do nothing.
`timescale 1ns/1ps
`include "dcc_defines.svh"

module dcc_channel (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire dcc_pkg::dcc_apb_req_t      apb_req,
  output logic [`DCC_DATA_W-1:0]          prdata,
  output logic                            pready,
  output logic                            pslverr,
  // source side
  input  wire logic                       src_hw_req,
  input  wire dcc_pkg::dcc_word_t         src_word,
  output logic                            src_ready,
  // destination side
  input  wire logic [`DCC_HW_IF_N-1:0]    dst_hw_req,
  output dcc_pkg::dcc_word_t              dst_word,
  input  wire logic                       dst_ready,
  // arbitration
  output logic [`DCC_RANK_W-1:0]          ch_rank,
  input  wire logic [`DCC_RANK_W-1:0]     peer_rank,
  input  wire logic                       peer_req,
  output logic                            ch_wins
);

  typedef struct packed {
    dcc_pkg::dcc_cfg_t      cfg;
    dcc_pkg::dcc_ctrl_t     ctrl;
    dcc_pkg::dcc_state_t    state;
    logic                   src_pend;
    logic                   dst_pend;
    logic                   src_meta;
    logic                   src_sync;
    logic [`DCC_HW_IF_N-1:0] dst_meta;
    logic [`DCC_HW_IF_N-1:0] dst_sync;
    logic [`DCC_DATA_W-1:0] rdata;
  } dcc_ch_st_t;

  dcc_ch_st_t             st_reg;
  dcc_ch_st_t             st_next;
  logic                   setup;
  logic                   access;
  logic                   wr;
  logic                   hit;
  logic                   src_go;
  logic                   src_take;
  logic                   dst_go;
  logic                   dst_take;
  logic                   fifo_in_ready;
  logic                   fifo_empty;
  logic [`DCC_CNT_W-1:0]  fifo_cnt;
  dcc_pkg::dcc_word_t     fifo_out;
  logic [`DCC_DATA_W-1:0] cfg_word;
  logic [`DCC_DATA_W-1:0] ctrl_word;
  logic [`DCC_DATA_W-1:0] stat_word;
  logic [`DCC_DATA_W-1:0] wcfg;
  logic [`DCC_DATA_W-1:0] wctrl;
  logic                   dst_hw_sel;

  // byte-lane merge of a write into an old word
  function automatic logic [`DCC_DATA_W-1:0] merge(
    input logic [`DCC_DATA_W-1:0] old,
    input logic [`DCC_DATA_W-1:0] wd,
    input logic [3:0]             strb
  );
    logic [`DCC_DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // address decode
  function automatic logic mapped(input logic [`DCC_ADDR_W-1:0] a);
    mapped = (a == `DCC_OFF_CTRL) || (a == `DCC_OFF_SWREQ) ||
             (a == `DCC_OFF_STATUS) || (a == `DCC_OFF_CFG_LOW);
  endfunction

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && apb_req.pwrite;
  assign hit    = mapped(apb_req.paddr);

  // register images; every unlisted bit is left zero
  always_comb begin
    cfg_word = '0;
    cfg_word[`DCC_CFG_SRC_HS] = st_reg.cfg.src_hs;
    cfg_word[`DCC_CFG_DST_HS] = st_reg.cfg.dst_hs;
    cfg_word[`DCC_CFG_EMPTY]  = fifo_empty; // R5
    cfg_word[`DCC_CFG_HOLD]   = st_reg.cfg.hold;
    cfg_word[`DCC_CFG_RANK_MSB:`DCC_CFG_RANK_LSB] = st_reg.cfg.rank;
    ctrl_word = '0;
    ctrl_word[`DCC_CTRL_EN]      = st_reg.ctrl.en;
    ctrl_word[`DCC_CTRL_SRC_MEM] = st_reg.ctrl.src_mem;
    ctrl_word[`DCC_CTRL_DST_MEM] = st_reg.ctrl.dst_mem;
    ctrl_word[`DCC_CTRL_DSEL_MSB:`DCC_CTRL_DSEL_LSB] = st_reg.ctrl.dsel;
    stat_word = '0;
    stat_word[`DCC_ST_STATE_MSB:`DCC_ST_STATE_LSB] = st_reg.state;
    stat_word[`DCC_ST_CNT_MSB:`DCC_ST_CNT_LSB] = fifo_cnt;
    stat_word[`DCC_ST_SRC_PEND] = st_reg.src_pend;
    stat_word[`DCC_ST_DST_PEND] = st_reg.dst_pend;
  end

  assign wcfg  = merge(cfg_word, apb_req.pwdata, apb_req.pstrb);
  assign wctrl = merge(ctrl_word, apb_req.pwdata, apb_req.pstrb);

  // source gate: memory ignores the choice, else one handshake only
  always_comb begin
    if (st_reg.ctrl.src_mem) begin
      src_go = 1'b1; // R3
    end else if (st_reg.cfg.src_hs) begin
      src_go = st_reg.src_pend; // R1
    end else begin
      src_go = st_reg.src_sync; // R1
    end
  end

  // interface numbers above 1 have nothing behind them
  assign dst_hw_sel = (st_reg.ctrl.dsel < `DCC_DSEL_W'(`DCC_HW_IF_N)) &&
                      st_reg.dst_sync[st_reg.ctrl.dsel[0]]; // R11

  always_comb begin
    if (st_reg.ctrl.dst_mem) begin
      dst_go = 1'b1; // R4
    end else if (st_reg.cfg.dst_hs) begin
      dst_go = st_reg.dst_pend; // R2
    end else begin
      dst_go = dst_hw_sel; // R2
    end
  end

  // hold cuts the source one cycle after channel_hold is set, mid-burst if need be
  assign src_take = (st_reg.state == dcc_pkg::DCC_RUN) &&
                    src_go && src_word.valid && fifo_in_ready; // R6 R7
  assign src_ready = (st_reg.state == dcc_pkg::DCC_RUN) &&
                     src_go && fifo_in_ready; // R6
  // the drain keeps running under hold so the fifo can empty
  assign dst_take = st_reg.ctrl.en && dst_go && fifo_out.valid &&
                    dst_ready;

  dcc_fifo #(
    .W  (`DCC_DATA_W),
    .D  (`DCC_FIFO_D),
    .CW (`DCC_CNT_W)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (src_take),
    .in_ready  (fifo_in_ready),
    .in_data   (src_word.data),
    .out_valid (fifo_out.valid),
    .out_ready (dst_take),
    .out_data  (fifo_out.data),
    .empty     (fifo_empty),
    .count     (fifo_cnt)
  );

  assign dst_word.valid = st_reg.ctrl.en && dst_go && fifo_out.valid;
  assign dst_word.data  = fifo_out.data;

  // zero-wait slave; read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = st_reg.rdata;

  // arbitration: higher rank wins, ties go to this channel
  assign ch_rank = st_reg.cfg.rank; // R9
  assign ch_wins = st_reg.ctrl.en && (!peer_req ||
                   (st_reg.cfg.rank >= peer_rank)); // R9

  always_comb begin
    st_next = st_reg;
    st_next.src_meta = src_hw_req;
    st_next.src_sync = st_reg.src_meta;
    st_next.dst_meta = dst_hw_req;
    st_next.dst_sync = st_reg.dst_meta;
    if (setup) begin
      unique case (apb_req.paddr)
        `DCC_OFF_CTRL:    st_next.rdata = ctrl_word;
        `DCC_OFF_STATUS:  st_next.rdata = stat_word;
        `DCC_OFF_CFG_LOW: st_next.rdata = cfg_word; // R12
        default:          st_next.rdata = '0;
      endcase
    end
    // a request consumed in the same cycle as a fresh write stays set
    if (src_take) begin
      st_next.src_pend = 1'b0;
    end
    if (dst_take) begin
      st_next.dst_pend = 1'b0;
    end
    if (wr) begin
      unique case (apb_req.paddr)
        `DCC_OFF_CFG_LOW: begin
          st_next.cfg.src_hs = wcfg[`DCC_CFG_SRC_HS]; // R1
          st_next.cfg.dst_hs = wcfg[`DCC_CFG_DST_HS]; // R2
          st_next.cfg.hold   = wcfg[`DCC_CFG_HOLD]; // R6
          st_next.cfg.rank   =
            wcfg[`DCC_CFG_RANK_MSB:`DCC_CFG_RANK_LSB]; // R9
        end
        `DCC_OFF_CTRL: begin
          st_next.ctrl.en      = wctrl[`DCC_CTRL_EN];
          st_next.ctrl.src_mem = wctrl[`DCC_CTRL_SRC_MEM];
          st_next.ctrl.dst_mem = wctrl[`DCC_CTRL_DST_MEM];
          st_next.ctrl.dsel    =
            wctrl[`DCC_CTRL_DSEL_MSB:`DCC_CTRL_DSEL_LSB];
        end
        `DCC_OFF_SWREQ: begin
          if (apb_req.pstrb[0] && apb_req.pwdata[`DCC_SWREQ_SRC]) begin
            st_next.src_pend = 1'b1;
          end
          if (apb_req.pstrb[0] && apb_req.pwdata[`DCC_SWREQ_DST]) begin
            st_next.dst_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (st_reg.state)
      dcc_pkg::DCC_IDLE: begin
        if (st_reg.ctrl.en) begin
          st_next.state = st_reg.cfg.hold ? dcc_pkg::DCC_HOLD
                                          : dcc_pkg::DCC_RUN;
        end
      end
      dcc_pkg::DCC_RUN: begin
        if (!st_reg.ctrl.en) begin
          st_next.state = dcc_pkg::DCC_IDLE;
        end else if (st_reg.cfg.hold) begin
          st_next.state = dcc_pkg::DCC_HOLD; // R6
        end
      end
      dcc_pkg::DCC_HOLD: begin
        if (!st_reg.ctrl.en) begin
          st_next.state = dcc_pkg::DCC_IDLE;
        end else if (!st_reg.cfg.hold) begin
          st_next.state = dcc_pkg::DCC_RUN; // R6
        end
      end
      default: st_next.state = dcc_pkg::DCC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg            <= '0;
      st_reg.cfg.src_hs <= `DCC_RST_SRC_HS; // R1
      st_reg.cfg.dst_hs <= `DCC_RST_DST_HS; // R2
      st_reg.cfg.hold   <= `DCC_RST_HOLD; // R6
      st_reg.cfg.rank   <= `DCC_RST_RANK; // R9
      st_reg.state      <= dcc_pkg::DCC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // checks

  src_sw_only_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    src_take && !st_reg.ctrl.src_mem && st_reg.cfg.src_hs
      |-> st_reg.src_pend)
    else $error("source taken without software request");

  src_hw_only_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    src_take && !st_reg.ctrl.src_mem && !st_reg.cfg.src_hs
      |-> st_reg.src_sync)
    else $error("source taken without hardware request");

  dst_choice_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    dst_take && !st_reg.ctrl.dst_mem
      |-> (st_reg.cfg.dst_hs ? st_reg.dst_pend : dst_hw_sel))
    else $error("destination drained on wrong handshake");

  src_mem_free_a: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl.src_mem && st_reg.state == dcc_pkg::DCC_RUN &&
    src_word.valid && fifo_in_ready |-> src_take)
    else $error("memory source stalled by handshake choice");

  dst_mem_free_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl.en && st_reg.ctrl.dst_mem && fifo_out.valid &&
    dst_ready |-> dst_take)
    else $error("memory destination stalled by handshake choice");

  empty_bit_a: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    access && !apb_req.pwrite && $past(setup) &&
    apb_req.paddr == `DCC_OFF_CFG_LOW && $stable(fifo_cnt)
      |-> prdata[`DCC_CFG_EMPTY] == (fifo_cnt == '0))
    else $error("empty bit disagrees with fifo");

  hold_stops_a: assert property ( // R6 R7
    @(posedge pclk) disable iff (!presetn)
    st_reg.cfg.hold |=> !src_take)
    else $error("source word taken while held");

  hold_resume_a: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl.en && !st_reg.cfg.hold && st_reg.state ==
      dcc_pkg::DCC_HOLD |=> st_reg.state == dcc_pkg::DCC_RUN)
    else $error("channel did not resume after hold cleared");

  rank_wins_a: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl.en && peer_req && peer_rank > ch_rank |-> !ch_wins)
    else $error("lower rank won arbitration");

  dsel_range_a: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    !st_reg.ctrl.dst_mem && !st_reg.cfg.dst_hs &&
    st_reg.ctrl.dsel > `DCC_DSEL_W'(1) |-> !dst_take)
    else $error("absent hardware interface drained the fifo");

  reserved_zero_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    access && $past(setup) && apb_req.paddr == `DCC_OFF_CFG_LOW
      |-> prdata[4:0] == 5'h00 && prdata[31:12] == 20'h00000)
    else $error("reserved bits read nonzero");

endmodule

// >>> rtl/dcc_fifo.sv
`timescale 1ns/1ps

module dcc_fifo #(
  parameter int W = 32,
  parameter int D = 4,
  parameter int CW = 3
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  // occupancy
  output logic               empty,
  output logic [CW-1:0]      count
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-1:0]       wp;
    logic [CW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } dcc_fifo_st_t;

  dcc_fifo_st_t st_reg;
  dcc_fifo_st_t st_next;
  logic         push;
  logic         pop;

  // pointers wrap by compare, so depth need not be a power of two
  function automatic logic [CW-1:0] bump(input logic [CW-1:0] p);
    bump = (p == CW'(D - 1)) ? '0 : CW'(p + 1'b1);
  endfunction

  assign in_ready  = (st_reg.cnt != CW'(D));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rp];
  assign empty     = (st_reg.cnt == '0);
  assign count     = st_reg.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = bump(st_reg.wp);
    end
    if (pop) begin
      st_next.rp = bump(st_reg.rp);
    end
    if (push && !pop) begin
      st_next.cnt = CW'(st_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      st_next.cnt = CW'(st_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
